//--- verilog/rx_cfg_regs.svh
// Purpose: register numbers, field positions and reset values of the receive configuration bank
// Assumes: registers are addressed by their register number on the management port
// Notes: every field resets to zero; reserved bits are kept as plain storage
`ifndef RX_CFG_REGS_SVH
`define RX_CFG_REGS_SVH

// register numbers on the management port
`define RX_PATH_CONTROL_ADDR 8'h04
`define RX_EQUALIZER_LOS_MODE_ADDR 8'h05
`define RX_THRESHOLD_HYSTERESIS_ADDR 8'h06
`define RX_LOS_ASSERT_LEVEL_ADDR 8'h07
`define RX_CFG_FIRST_ADDR 8'h04
`define RX_CFG_COUNT 4
`define RX_CFG_RESET 8'h00
`define RX_UNMAPPED_READ 8'h00

// path control fields
`define POWERDOWN_BIT 7
`define DRIVER_OFF_BIT 6
`define OUTPUT_INVERT_BIT 5
`define RECOVERY_OFF_BIT 4
`define RECOVERY_BYPASS_BIT 3
`define OFFSET_CANCEL_OFF_BIT 2
`define EQUALIZER_OFF_BIT 1
`define LOSS_RANGE_BIT 0

// equalizer and signal-loss mode fields
`define FAST_LOSS_BIT 3
`define EQ_STRENGTH_MSB 2
`define EQ_STRENGTH_LSB 0

// threshold fields
`define HYSTERESIS_BIT 7
`define SHIFT_DIRECTION_BIT 4
`define SHIFT_MAGNITUDE_MSB 3
`define SHIFT_MAGNITUDE_LSB 0

// assert level field
`define LOSS_LEVEL_MSB 5
`define LOSS_LEVEL_LSB 0

`endif

//--- verilog/rx_cfg_pkg.sv
// Purpose: types shared by the receive configuration bank and its users
// Assumes: nothing beyond the register header
// Notes: the control word is what the analog receive path consumes
package rx_cfg_pkg;

	typedef logic [7:0] cfg_byte_type;

	// decoded controls handed to the receive path
	typedef struct packed {
		logic receive_powerdown;
		logic receive_driver_off;
		logic receive_output_invert;
		logic receive_recovery_off;
		logic receive_recovery_bypass;
		logic receive_offset_cancel_off;
		logic receive_equalizer_off;
		logic signal_loss_range_select;
		logic fast_signal_loss_select;
		logic [2:0] input_equalizer_strength;
		logic hysteresis_reduce;
		logic crosspoint_shift_direction;
		logic [3:0] crosspoint_shift_magnitude;
		logic [5:0] signal_loss_assert_level;
	} rx_ctrl_type;

endpackage

//--- verilog/rx_path_config_registers.sv
// Purpose: four receive path configuration registers with decoded control outputs
// Assumes: management port is synchronous to CLK; transmit bypass bit comes from same-clock logic
// Notes: controls follow the registers one cycle later; CE low freezes every flip-flop while RESETN is high
`timescale 1ns/10ps
`include "rx_cfg_regs.svh"

module rx_path_config_registers (
	input wire logic CLK, // 20 MHz system clock
	input wire logic RESETN, // synchronous reset, active low
	input wire logic CE, // clock enable, freezes all state when low unless RESETN is low
	input wire logic [7:0] REG_ADDR, // register number
	input wire logic REG_WRITE, // write strobe, one cycle
	input wire logic REG_READ, // read strobe, one cycle
	input wire logic [7:0] REG_WDATA, // write data
	input wire logic TX_BYPASS_REQ, // transmit recovery bypass bit from the transmit bank
	output rx_cfg_pkg::cfg_byte_type REG_RDATA, // read data, valid the cycle after REG_READ
	output rx_cfg_pkg::rx_ctrl_type RX_CTRL // decoded receive path controls
);

	rx_cfg_pkg::cfg_byte_type cfg [`RX_CFG_COUNT];
	rx_cfg_pkg::rx_ctrl_type next_ctrl;

	// true when the address falls inside this bank
	function automatic logic addr_hit(input logic [7:0] addr);
		addr_hit = (addr >= `RX_CFG_FIRST_ADDR) &&
			(addr < (`RX_CFG_FIRST_ADDR + 8'(`RX_CFG_COUNT)));
	endfunction

	// index of a register within the bank
	function automatic logic [1:0] addr_index(input logic [7:0] addr);
		logic [7:0] offset;
		offset = addr - `RX_CFG_FIRST_ADDR;
		addr_index = offset[1:0];
	endfunction

	// storage: every bit, reserved ones included, is plain read/write
	genvar gi;
	generate
		for (gi = 0; gi < `RX_CFG_COUNT; gi++) begin : g_cfg
			always_ff @(posedge CLK) begin
				if (!RESETN) begin
					cfg[gi] <= `RX_CFG_RESET;
				end else if (CE && REG_WRITE && addr_hit(REG_ADDR) &&
					addr_index(REG_ADDR) == 2'(gi)) begin
					cfg[gi] <= REG_WDATA;
				end
			end
		end
	endgenerate

	// read path; unmapped numbers read zero so the serial side always has an answer
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			REG_RDATA <= `RX_UNMAPPED_READ;
		end else if (CE && REG_READ) begin
			if (addr_hit(REG_ADDR)) begin
				REG_RDATA <= cfg[addr_index(REG_ADDR)];
			end else begin
				REG_RDATA <= `RX_UNMAPPED_READ;
			end
		end
	end

	// decode fields into the control word
	always_comb begin
		next_ctrl.receive_powerdown = cfg[0][`POWERDOWN_BIT];
		next_ctrl.receive_driver_off = cfg[0][`DRIVER_OFF_BIT];
		next_ctrl.receive_output_invert = cfg[0][`OUTPUT_INVERT_BIT];
		next_ctrl.receive_recovery_off = cfg[0][`RECOVERY_OFF_BIT];
		// bypass alone would leave the two paths mismatched, so both bits are required
		next_ctrl.receive_recovery_bypass = cfg[0][`RECOVERY_BYPASS_BIT] & TX_BYPASS_REQ;
		next_ctrl.receive_offset_cancel_off = cfg[0][`OFFSET_CANCEL_OFF_BIT];
		next_ctrl.receive_equalizer_off = cfg[0][`EQUALIZER_OFF_BIT];
		next_ctrl.signal_loss_range_select = cfg[0][`LOSS_RANGE_BIT];
		next_ctrl.fast_signal_loss_select = cfg[1][`FAST_LOSS_BIT];
		next_ctrl.input_equalizer_strength =
			cfg[1][`EQ_STRENGTH_MSB:`EQ_STRENGTH_LSB];
		next_ctrl.hysteresis_reduce = cfg[2][`HYSTERESIS_BIT];
		next_ctrl.crosspoint_shift_direction = cfg[2][`SHIFT_DIRECTION_BIT];
		next_ctrl.crosspoint_shift_magnitude =
			cfg[2][`SHIFT_MAGNITUDE_MSB:`SHIFT_MAGNITUDE_LSB];
		next_ctrl.signal_loss_assert_level =
			cfg[3][`LOSS_LEVEL_MSB:`LOSS_LEVEL_LSB];
	end

	// registered controls keep the analog side free of decode glitches
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			RX_CTRL <= '0;
		end else if (CE) begin
			RX_CTRL <= next_ctrl;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	// reset clears every register and the control word
	reset_clears_all_a: assert property (disable iff (1'b0)
		!RESETN |=> (cfg[0] == 8'h00 && cfg[1] == 8'h00 && cfg[2] == 8'h00 &&
		cfg[3] == 8'h00 && RX_CTRL == '0))
		else $error("registers not cleared by reset");

	// a write to the assert level register lands and is read back whole, reserved bits included
	write_readback_a: assert property (
		CE && REG_WRITE && REG_ADDR == `RX_LOS_ASSERT_LEVEL_ADDR ##1
		CE && REG_READ && !REG_WRITE && REG_ADDR == `RX_LOS_ASSERT_LEVEL_ADDR
		|=> REG_RDATA == $past(REG_WDATA, 2))
		else $error("assert level register read back differs from write");

	powerdown_follow_a: assert property (
		CE |=> RX_CTRL.receive_powerdown == $past(cfg[0][`POWERDOWN_BIT]))
		else $error("powerdown does not follow its bit");

	driver_gate_a: assert property (
		CE |=> RX_CTRL.receive_driver_off == $past(cfg[0][`DRIVER_OFF_BIT]))
		else $error("driver gate does not follow its bit");

	polarity_sel_a: assert property (
		CE |=> RX_CTRL.receive_output_invert == $past(cfg[0][`OUTPUT_INVERT_BIT]))
		else $error("output polarity does not follow its bit");

	recovery_off_a: assert property (
		CE |=> RX_CTRL.receive_recovery_off == $past(cfg[0][`RECOVERY_OFF_BIT]))
		else $error("recovery disable does not follow its bit");

	bypass_needs_both_a: assert property (
		CE |=> RX_CTRL.receive_recovery_bypass ==
		($past(cfg[0][`RECOVERY_BYPASS_BIT]) && $past(TX_BYPASS_REQ)))
		else $error("recovery bypass not gated by transmit bypass");

	offset_cancel_a: assert property (
		CE |=> RX_CTRL.receive_offset_cancel_off == $past(cfg[0][`OFFSET_CANCEL_OFF_BIT]))
		else $error("offset cancel disable does not follow its bit");

	equalizer_off_a: assert property (
		CE |=> RX_CTRL.receive_equalizer_off == $past(cfg[0][`EQUALIZER_OFF_BIT]))
		else $error("equalizer disable does not follow its bit");

	loss_range_a: assert property (
		CE |=> RX_CTRL.signal_loss_range_select == $past(cfg[0][`LOSS_RANGE_BIT]))
		else $error("loss range does not follow its bit");

	eq_mode_fields_a: assert property (
		CE |=> RX_CTRL.fast_signal_loss_select == $past(cfg[1][`FAST_LOSS_BIT]) &&
		RX_CTRL.input_equalizer_strength == $past(cfg[1][2:0]))
		else $error("equalizer mode fields do not follow register");

	eq_strength_a: assert property (
		CE && REG_WRITE && REG_ADDR == `RX_EQUALIZER_LOS_MODE_ADDR ##1 CE
		|=> RX_CTRL.input_equalizer_strength == $past(REG_WDATA[2:0], 2))
		else $error("equalizer strength not applied two cycles after write");

	threshold_fields_a: assert property (
		CE |=> RX_CTRL.hysteresis_reduce == $past(cfg[2][`HYSTERESIS_BIT]) &&
		RX_CTRL.crosspoint_shift_direction == $past(cfg[2][`SHIFT_DIRECTION_BIT]))
		else $error("hysteresis or shift direction does not follow register");

	shift_magnitude_a: assert property (
		CE |=> RX_CTRL.crosspoint_shift_magnitude == $past(cfg[2][3:0]))
		else $error("shift magnitude does not follow register");

	loss_level_a: assert property (
		CE |=> RX_CTRL.signal_loss_assert_level == $past(cfg[3][5:0]))
		else $error("assert level does not follow register");

	freeze_hold_a: assert property (
		!CE |=> $stable(RX_CTRL) && $stable(REG_RDATA) && $stable(cfg[2]))
		else $error("state changed while clock enable low");

	cover_bypass_on_c: cover property (RX_CTRL.receive_recovery_bypass);
	cover_bypass_held_c: cover property (cfg[0][`RECOVERY_BYPASS_BIT] && !TX_BYPASS_REQ);
	cover_powerdown_c: cover property ($rose(RX_CTRL.receive_powerdown));
	cover_unmapped_c: cover property (CE && REG_READ && !addr_hit(REG_ADDR));
	cover_readback_c: cover property (CE && REG_READ && addr_hit(REG_ADDR));

	// shift direction is its own bit and must not ride on the magnitude field
	shift_direction_a: assert property (
		CE |=> RX_CTRL.crosspoint_shift_direction == $past(cfg[2][`SHIFT_DIRECTION_BIT]))
		else $error("shift direction does not follow its bit");

	// read data is cleared by reset like every other flip-flop
	rdata_reset_a: assert property (disable iff (1'b0)
		!RESETN |=> REG_RDATA == 8'h00)
		else $error("read data not cleared by reset");

	// reset wins over a low clock enable, so a frozen bank still clears
	reset_beats_ce_a: assert property (disable iff (1'b0)
		!RESETN && !CE |=> RX_CTRL == '0 && cfg[0] == 8'h00 && cfg[3] == 8'h00)
		else $error("reset did not win over clock enable");

	// a write to path control lands whole at the strobe edge
	write_path_ctrl_a: assert property (
		CE && REG_WRITE && REG_ADDR == `RX_PATH_CONTROL_ADDR
		|=> cfg[0] == $past(REG_WDATA))
		else $error("path control write did not land");

	// a write to the equalizer register lands whole
	write_eq_mode_a: assert property (
		CE && REG_WRITE && REG_ADDR == `RX_EQUALIZER_LOS_MODE_ADDR
		|=> cfg[1] == $past(REG_WDATA))
		else $error("equalizer mode write did not land");

	// a write to the threshold register lands whole
	write_threshold_a: assert property (
		CE && REG_WRITE && REG_ADDR == `RX_THRESHOLD_HYSTERESIS_ADDR
		|=> cfg[2] == $past(REG_WDATA))
		else $error("threshold write did not land");

	// a write to the assert level register lands whole
	write_loss_level_a: assert property (
		CE && REG_WRITE && REG_ADDR == `RX_LOS_ASSERT_LEVEL_ADDR
		|=> cfg[3] == $past(REG_WDATA))
		else $error("assert level write did not land");

	// reserved upper nibble of the equalizer register is real storage
	reserved_eq_a: assert property (
		CE && REG_WRITE && REG_ADDR == `RX_EQUALIZER_LOS_MODE_ADDR
		|=> cfg[1][7:4] == $past(REG_WDATA[7:4]))
		else $error("reserved equalizer bits not stored");

	// reserved bits of the threshold register are real storage
	reserved_thresh_a: assert property (
		CE && REG_WRITE && REG_ADDR == `RX_THRESHOLD_HYSTERESIS_ADDR
		|=> cfg[2][6:5] == $past(REG_WDATA[6:5]))
		else $error("reserved threshold bits not stored");

	// reserved top bits of the assert level register are real storage
	reserved_level_a: assert property (
		CE && REG_WRITE && REG_ADDR == `RX_LOS_ASSERT_LEVEL_ADDR
		|=> cfg[3][7:6] == $past(REG_WDATA[7:6]))
		else $error("reserved assert level bits not stored");

	// without a taken write into the bank no register may move
	cfg_hold_a: assert property (
		!(CE && REG_WRITE && addr_hit(REG_ADDR))
		|=> $stable(cfg[0]) && $stable(cfg[1]) && $stable(cfg[2]) && $stable(cfg[3]))
		else $error("register changed without a write");

	// a write outside the bank must leave all four registers alone
	unmapped_write_a: assert property (
		CE && REG_WRITE && !addr_hit(REG_ADDR)
		|=> $stable(cfg[0]) && $stable(cfg[1]) && $stable(cfg[2]) && $stable(cfg[3]))
		else $error("unmapped write disturbed the bank");

	// a frozen bank ignores every strobe
	freeze_regs_a: assert property (
		!CE |=> $stable(cfg[0]) && $stable(cfg[1]) && $stable(cfg[3]))
		else $error("register changed while clock enable low");

	// unmapped numbers always answer zero so the serial side never stalls
	unmapped_read_a: assert property (
		CE && REG_READ && !addr_hit(REG_ADDR) |=> REG_RDATA == 8'h00)
		else $error("unmapped read did not return zero");

	// a read returns the value from before any same-cycle write
	read_path_ctrl_a: assert property (
		CE && REG_READ && REG_ADDR == `RX_PATH_CONTROL_ADDR
		|=> REG_RDATA == $past(cfg[0]))
		else $error("path control read differs from register");

	// equalizer register read back
	read_eq_mode_a: assert property (
		CE && REG_READ && REG_ADDR == `RX_EQUALIZER_LOS_MODE_ADDR
		|=> REG_RDATA == $past(cfg[1]))
		else $error("equalizer mode read differs from register");

	// threshold register read back
	read_threshold_a: assert property (
		CE && REG_READ && REG_ADDR == `RX_THRESHOLD_HYSTERESIS_ADDR
		|=> REG_RDATA == $past(cfg[2]))
		else $error("threshold read differs from register");

	// assert level register read back
	read_loss_level_a: assert property (
		CE && REG_READ && REG_ADDR == `RX_LOS_ASSERT_LEVEL_ADDR
		|=> REG_RDATA == $past(cfg[3]))
		else $error("assert level read differs from register");

	// read data stands until the next taken read
	rdata_hold_a: assert property (
		!(CE && REG_READ) |=> $stable(REG_RDATA))
		else $error("read data changed without a read");

	// the receive bit alone must never bypass recovery
	bypass_tx_low_a: assert property (
		CE && !TX_BYPASS_REQ |=> !RX_CTRL.receive_recovery_bypass)
		else $error("bypass active without transmit bypass");

	// the transmit bit alone must never bypass receive recovery
	bypass_rx_low_a: assert property (
		CE && !cfg[0][`RECOVERY_BYPASS_BIT] |=> !RX_CTRL.receive_recovery_bypass)
		else $error("bypass active without receive bypass bit");

endmodule

//--- sim/tb.sv
// Purpose: self-checking bench for the receive configuration bank
// Assumes: strobes are taken at a rising edge with CE high; read data lands one cycle later
// Notes: each operation starts one edge after the last, so no strobe changes twice at once
`timescale 1ns/10ps
`include "rx_cfg_regs.svh"

module tb;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic CE = 1'b1;
	logic REG_WRITE = 1'b0;
	logic REG_READ = 1'b0;
	logic TX_BYPASS_REQ = 1'b0;
	logic [7:0] REG_ADDR = 8'h00;
	logic [7:0] REG_WDATA = 8'h00;
	rx_cfg_pkg::cfg_byte_type REG_RDATA;
	rx_cfg_pkg::rx_ctrl_type RX_CTRL;
	logic [7:0] mdl [4] = '{default: 8'h00};
	int n_errors = 0;
	int n_checks = 0;
	int cycles = 0;

	rx_path_config_registers rx_path_config_registers_i (
		.CLK(CLK), .RESETN(RESETN), .CE(CE), .REG_ADDR(REG_ADDR), .REG_WRITE(REG_WRITE),
		.REG_READ(REG_READ), .REG_WDATA(REG_WDATA), .TX_BYPASS_REQ(TX_BYPASS_REQ),
		.REG_RDATA(REG_RDATA), .RX_CTRL(RX_CTRL)
	);

	// 50 ns clock
	always #25 CLK = ~CLK;

	task automatic close_out();
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// a hang is cut off well past the expected run of a few hundred cycles
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			close_out();
		end
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// expected controls from the shadow copy; bypass needs the transmit bit as well
	function automatic rx_cfg_pkg::rx_ctrl_type model_ctrl();
		return {mdl[0][7:4], mdl[0][3] & TX_BYPASS_REQ, mdl[0][2:0], mdl[1][3:0],
			mdl[2][7], mdl[2][4:0], mdl[3][5:0]};
	endfunction

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge CLK);
		#1 REG_ADDR = addr;
		REG_WDATA = data;
		REG_WRITE = 1'b1;
		if (CE && addr >= 8'h04 && addr <= 8'h07) begin
			mdl[addr - 8'h04] = data;
		end
		@(posedge CLK);
		#1 REG_WRITE = 1'b0;
	endtask

	// unmapped places read back as zero
	task automatic rdchk(input logic [7:0] addr);
		logic [7:0] exp;
		exp = (addr >= 8'h04 && addr <= 8'h07) ? mdl[addr - 8'h04] : 8'h00;
		@(posedge CLK);
		#1 REG_ADDR = addr;
		REG_READ = 1'b1;
		@(posedge CLK);
		#1 REG_READ = 1'b0;
		chk({16'h0000, REG_RDATA}, {16'h0000, exp}, "read data");
	endtask

	// controls lag the registers by one cycle
	task automatic ctlchk();
		@(posedge CLK);
		#1 chk(RX_CTRL, model_ctrl(), "controls");
	endtask

	initial begin
		repeat (3) @(posedge CLK);
		#1 RESETN = 1'b1;
		// reset values of all four registers and of the controls
		for (int a = 4; a < 8; a++) rdchk(8'(a));
		ctlchk();
		// walking one through every bit, reserved ones included
		for (int r = 0; r < 4; r++) begin
			for (int b = 0; b < 8; b++) begin
				wr(8'(4 + r), 8'h01 << b);
				ctlchk();
				rdchk(8'(4 + r));
			end
			wr(8'(4 + r), 8'hff);
			ctlchk();
			rdchk(8'(4 + r));
		end
		// bypass takes effect only with the transmit bit set
		wr(8'h04, 8'h08);
		TX_BYPASS_REQ = 1'b1;
		ctlchk();
		TX_BYPASS_REQ = 1'b0;
		ctlchk();
		rdchk(8'h04);
		// the transmit bit alone leaves recovery in the path
		wr(8'h04, 8'hf7);
		TX_BYPASS_REQ = 1'b1;
		ctlchk();
		TX_BYPASS_REQ = 1'b0;
		// unmapped writes leave the bank alone
		wr(8'h08, 8'h5a);
		wr(8'h03, 8'ha5);
		rdchk(8'h08);
		rdchk(8'h03);
		for (int a = 4; a < 8; a++) rdchk(8'(a));
		// a write strobe is ignored while the clock enable is low
		CE = 1'b0;
		wr(8'h05, 8'h3c);
		CE = 1'b1;
		rdchk(8'h05);
		// a second reset in mid-run clears everything
		wr(8'h06, 8'h9f);
		@(posedge CLK);
		#1 RESETN = 1'b0;
		@(posedge CLK);
		#1 RESETN = 1'b1;
		mdl = '{default: 8'h00};
		for (int a = 4; a < 8; a++) rdchk(8'(a));
		ctlchk();
		close_out();
	end
endmodule
